/* qwr_defines.svh */
`ifndef QWR_DEFINES_SVH
`define QWR_DEFINES_SVH

// ------------------------------------------------------------
// opcodes
// ------------------------------------------------------------
`define QWR_OP_WORD      8'he7
`define QWR_OP_OCTAL     8'he3
`define QWR_OP_WRAP      8'h77
`define QWR_OP_CRM_RESET 8'hff
`define QWR_OP_RST_EN    8'h66
`define QWR_OP_RST       8'h99

// ------------------------------------------------------------
// phase lengths in serial clocks
// ------------------------------------------------------------
`define QWR_OPC_CLKS_SPI 5'h08
`define QWR_OPC_CLKS_QPI 5'h02
`define QWR_ADDR_CLKS    5'h06
`define QWR_MODE_CLKS    5'h02
`define QWR_DUMMY_WORD   5'h02
`define QWR_DUMMY_OCTAL  5'h00
`define QWR_WDUM_CLKS    5'h06
`define QWR_WBITS_CLKS   5'h02

// ------------------------------------------------------------
// field values and positions
// ------------------------------------------------------------
`define QWR_CONT_SEL      2'h2
`define QWR_SEL_HI        5
`define QWR_SEL_LO        4
`define QWR_W_HI          6
`define QWR_W_LO          4
`define QWR_WRAP_RESET    3'h1
`define QWR_CONT_RESET    8'h00
`define QWR_WORD_ALIGN    24'h000001
`define QWR_OCTAL_ALIGN   24'h00000f
`define QWR_WRAP_MASK_8   24'h000007
`define QWR_WRAP_MASK_16  24'h00000f
`define QWR_WRAP_MASK_32  24'h00001f
`define QWR_WRAP_MASK_64  24'h00003f

`endif

/* qwr_pkg.sv */
package qwr_pkg;

	// host pins as seen by the device
	typedef struct packed {
		logic       sclk;
		logic       cs_b;
		logic [3:0] io;
	} qwr_pins_t;

	// frame phases
	typedef enum logic [3:0] {
		qwr_ph_idle,
		qwr_ph_opcode,
		qwr_ph_addr,
		qwr_ph_mode,
		qwr_ph_dummy,
		qwr_ph_data,
		qwr_ph_wdummy,
		qwr_ph_wbits,
		qwr_ph_ignore
	} qwr_phase_t;

	// read variant
	typedef enum logic {
		qwr_kind_word,
		qwr_kind_octal
	} qwr_kind_t;

endpackage

/* qwr_sync.sv */
`timescale 1ns/100ps

// two-flop synchroniser for the host pins
module qwr_sync (
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_rst_b,
	// raw and synchronised pins
	input  wire qwr_pkg::qwr_pins_t i_pins,
	output qwr_pkg::qwr_pins_t      o_pins
);

	qwr_pkg::qwr_pins_t meta;

	// idle value keeps the frame closed during reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			meta   <= '{sclk: 1'b0, cs_b: 1'b1, io: 4'h0};
			o_pins <= '{sclk: 1'b0, cs_b: 1'b1, io: 4'h0};
		end else begin
			meta   <= i_pins;
			o_pins <= meta;
		end
	end

endmodule

/* qwr_core.sv */
// How it works
// RQ1 - word read: address bit 0 zero, exactly two dummy clocks after mode bits
// RQ2 - word read opcode accepted only with quad lane enable set
// RQ3 - eight mode bits follow address; upper nibble used, lower nibble ignored
// RQ4 - mode pair 10 makes next frame skip opcode, address taken at once
// RQ5 - any other mode pair makes the next frame start with an opcode
// RQ6 - host leaves continuous reads by driving ones on lane zero eight clocks
// RQ7 - two-command software reset leaves continuous-read bits untouched
// RQ8 - continuous-read reset opcode clears all eight continuous-read bits
// RQ9 - octal word read: low four address bits zero, no dummy clocks
// RQ10 - octal word read opcode accepted only with quad lane enable set
// RQ11 - octal read with mode pair 10 lets next frame start at address
// RQ12 - host releases io lanes before first data falling edge
// RQ13 - set-wrap is opcode, 24 dummy bits, 8 wrap bits; W7, W3-0 ignored
// RQ14 - wrap disable clear wraps in 8/16/32/64 bytes by length field
// RQ15 - wrap disable bit is one after reset
// RQ16 - wrapped read starts at address, returns to section start until frame ends
// RQ17 - stored wrap setting applies to all later quad reads
// RQ18 - quad reads and set-wrap honoured only with quad lane enable set; opcode-less frames after mode pair 10 still read with it clear
// RQ19 - wrap length stays valid in four-wire command mode
// RQ20 - four-wire command mode reads never wrap
// RQ21 - opcode-less frame repeats the variant that set the mode bits
`timescale 1ns/100ps
`include "qwr_defines.svh"

module qwr_core (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// host pins
	input  wire logic        i_sclk,
	input  wire logic        i_cs_b,
	input  wire logic [3:0]  i_io,
	output logic      [3:0]  o_io_out,
	output logic      [3:0]  o_io_oe_b,
	// device configuration
	input  wire logic        i_quad_lane_enable_bit,
	input  wire logic        i_four_wire_command_mode,
	// array read port
	output logic      [23:0] o_rd_addr,
	output logic             o_rd_req,
	input  wire logic [7:0]  i_rd_data,
	// status
	output logic      [7:0]  o_continuous_read_bits,
	output logic      [2:0]  o_wrap_control_bits,
	output logic             o_misaligned,
	output logic             o_soft_reset
);

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	qwr_pkg::qwr_pins_t pins;
	qwr_pkg::qwr_pins_t pins_d;

	qwr_sync u_sync (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_pins  (qwr_pkg::qwr_pins_t'({i_sclk, i_cs_b, i_io})),
		.o_pins  (pins)
	);

	// edge history for the synchronised pins
	always_ff @(posedge i_clk) begin
		if (!i_rst_b)
			pins_d <= '{sclk: 1'b0, cs_b: 1'b1, io: 4'h0};
		else
			pins_d <= pins;
	end

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	qwr_pkg::qwr_phase_t phase;
	qwr_pkg::qwr_phase_t next_phase;
	qwr_pkg::qwr_kind_t  kind;
	qwr_pkg::qwr_kind_t  cont_kind;
	logic [4:0]          cnt;
	logic [23:0]         sh;
	logic [23:0]         start_addr;
	logic [7:0]          rd_byte;
	logic                rd_pend;
	logic                nib;
	logic                rst_armed;

	// edges and frame events
	wire        rise       = pins.sclk & ~pins_d.sclk & ~pins.cs_b;
	wire        fall       = ~pins.sclk & pins_d.sclk & ~pins.cs_b;
	wire        frame_go   = ~pins.cs_b & pins_d.cs_b;
	wire        frame_end  = pins.cs_b & ~pins_d.cs_b;
	wire        four_wire_command_mode        = i_four_wire_command_mode;
	wire [23:0] sh_one     = {sh[22:0], pins.io[0]};
	wire [23:0] sh_four    = {sh[19:0], pins.io};
	wire [23:0] sh_next    = (phase == qwr_pkg::qwr_ph_opcode && !four_wire_command_mode) ? sh_one : sh_four;
	wire [7:0]  opc        = sh_next[7:0];
	wire [4:0]  cnt_inc    = cnt + 5'h01;

	// phase length for the current phase
	wire [4:0]  dummy_clks = (kind == qwr_pkg::qwr_kind_word) ? `QWR_DUMMY_WORD
	                                                          : `QWR_DUMMY_OCTAL;
	wire [4:0]  opc_clks   = four_wire_command_mode ? `QWR_OPC_CLKS_QPI : `QWR_OPC_CLKS_SPI;
	wire [4:0]  ph_len     =
		(phase == qwr_pkg::qwr_ph_opcode) ? opc_clks :
		(phase == qwr_pkg::qwr_ph_addr)   ? `QWR_ADDR_CLKS :
		(phase == qwr_pkg::qwr_ph_mode)   ? `QWR_MODE_CLKS :
		(phase == qwr_pkg::qwr_ph_dummy)  ? dummy_clks :
		(phase == qwr_pkg::qwr_ph_wdummy) ? `QWR_WDUM_CLKS : `QWR_WBITS_CLKS;
	wire        ph_done    = rise && (cnt_inc == ph_len);

	// RQ2 quad enable gate
	wire        op_word    = (opc == `QWR_OP_WORD) && i_quad_lane_enable_bit;
	// RQ10 quad enable gate
	wire        op_octal   = (opc == `QWR_OP_OCTAL) && i_quad_lane_enable_bit;
	// RQ18 quad enable gate
	wire        op_wrap    = (opc == `QWR_OP_WRAP) && i_quad_lane_enable_bit;
	wire        op_crm     = (opc == `QWR_OP_CRM_RESET);
	wire        op_rst     = (opc == `QWR_OP_RST) && rst_armed;
	wire        opc_done   = ph_done && phase == qwr_pkg::qwr_ph_opcode;
	wire        mode_done  = ph_done && phase == qwr_pkg::qwr_ph_mode;
	wire        wbits_done = ph_done && phase == qwr_pkg::qwr_ph_wbits;

	// RQ4 cont frame test
	wire        cont_on    = o_continuous_read_bits[`QWR_SEL_HI:`QWR_SEL_LO] == `QWR_CONT_SEL;

	// ------------------------------------------------------------
	// phase sequencing
	// ------------------------------------------------------------
	always_comb begin
		next_phase = phase;
		case (phase)
			qwr_pkg::qwr_ph_opcode: begin
				if (opc_done)
					next_phase = (op_word || op_octal) ? qwr_pkg::qwr_ph_addr :
					             op_wrap ? qwr_pkg::qwr_ph_wdummy : qwr_pkg::qwr_ph_ignore;
			end
			qwr_pkg::qwr_ph_addr: begin
				if (ph_done)
					next_phase = qwr_pkg::qwr_ph_mode;
			end
			// RQ9 octal skips dummy
			qwr_pkg::qwr_ph_mode: begin
				if (ph_done)
					next_phase = (dummy_clks == 5'h00) ? qwr_pkg::qwr_ph_data
					                                   : qwr_pkg::qwr_ph_dummy;
			end
			// RQ1 two dummy clocks
			qwr_pkg::qwr_ph_dummy: begin
				if (ph_done)
					next_phase = qwr_pkg::qwr_ph_data;
			end
			// RQ13 dummy then wrap bits
			qwr_pkg::qwr_ph_wdummy: begin
				if (ph_done)
					next_phase = qwr_pkg::qwr_ph_wbits;
			end
			qwr_pkg::qwr_ph_wbits: begin
				if (ph_done)
					next_phase = qwr_pkg::qwr_ph_ignore;
			end
			qwr_pkg::qwr_ph_idle,
			qwr_pkg::qwr_ph_data,
			qwr_pkg::qwr_ph_ignore: next_phase = phase;
			default: next_phase = qwr_pkg::qwr_ph_idle;
		endcase
		// a frame edge overrides everything; RQ4, RQ5 and RQ11 choose entry
		if (frame_end)
			next_phase = qwr_pkg::qwr_ph_idle;
		else if (frame_go)
			next_phase = cont_on ? qwr_pkg::qwr_ph_addr : qwr_pkg::qwr_ph_opcode;
	end

	// phase, counter and shift register
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			phase <= qwr_pkg::qwr_ph_idle;
			cnt   <= 5'h00;
			sh    <= 24'h000000;
		end else begin
			phase <= next_phase;
			if (frame_go || ph_done)
				cnt <= 5'h00;
			else if (rise)
				cnt <= cnt_inc;
			if (rise)
				sh <= sh_next;
		end
	end

	// ------------------------------------------------------------
	// command variant and continuous-read bits
	// ------------------------------------------------------------
	// RQ21 cont frame reuses variant
	always_ff @(posedge i_clk) begin
		if (!i_rst_b)
			kind <= qwr_pkg::qwr_kind_word;
		else if (frame_go && cont_on)
			kind <= cont_kind;
		else if (opc_done)
			kind <= op_octal ? qwr_pkg::qwr_kind_octal : qwr_pkg::qwr_kind_word;
	end

	// RQ3 upper nibble kept; RQ8 reset opcode clears; RQ6 lane zero ones give x1
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_continuous_read_bits <= `QWR_CONT_RESET;
			cont_kind              <= qwr_pkg::qwr_kind_word;
		end else if (mode_done) begin
			o_continuous_read_bits <= {sh_next[7:4], 4'h0};
			cont_kind              <= kind;
		end else if (opc_done && op_crm) begin
			o_continuous_read_bits <= `QWR_CONT_RESET;
		end
	end

	// RQ7 software reset leaves continuous bits alone
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			rst_armed    <= 1'b0;
			o_soft_reset <= 1'b0;
		end else begin
			o_soft_reset <= opc_done && op_rst;
			if (opc_done)
				rst_armed <= (opc == `QWR_OP_RST_EN);
		end
	end

	// ------------------------------------------------------------
	// wrap setting
	// ------------------------------------------------------------
	// RQ13 keep W6-W4 only; RQ15 disabled at reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_b)
			o_wrap_control_bits <= `QWR_WRAP_RESET;
		else if (o_soft_reset)
			o_wrap_control_bits <= `QWR_WRAP_RESET;
		else if (wbits_done)
			o_wrap_control_bits <= sh_next[`QWR_W_HI:`QWR_W_LO];
	end

	// RQ14 section mask from length field
	wire [23:0] wrap_mask =
		(o_wrap_control_bits[2:1] == 2'h0) ? `QWR_WRAP_MASK_8 :
		(o_wrap_control_bits[2:1] == 2'h1) ? `QWR_WRAP_MASK_16 :
		(o_wrap_control_bits[2:1] == 2'h2) ? `QWR_WRAP_MASK_32 : `QWR_WRAP_MASK_64;
	// RQ20 four-wire mode reads stay linear; RQ19 length kept for later
	wire        wrap_on   = ~o_wrap_control_bits[0] & ~four_wire_command_mode;
	wire [23:0] addr_inc  = o_rd_addr + 24'h000001;
	// RQ16 stay inside the aligned section
	wire [23:0] addr_nx   = wrap_on ? ((o_rd_addr & ~wrap_mask) | (addr_inc & wrap_mask))
	                                : addr_inc;
	wire [23:0] align     = (kind == qwr_pkg::qwr_kind_word) ? `QWR_WORD_ALIGN
	                                                         : `QWR_OCTAL_ALIGN;
	wire        addr_done = ph_done && phase == qwr_pkg::qwr_ph_addr;
	wire        to_data   = next_phase == qwr_pkg::qwr_ph_data && phase != qwr_pkg::qwr_ph_data;
	wire        nib_step  = fall && phase == qwr_pkg::qwr_ph_data;

	// ------------------------------------------------------------
	// address and array fetch
	// ------------------------------------------------------------
	// RQ17 every read outside four-wire command mode applies the stored setting
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_rd_addr    <= 24'h000000;
			start_addr   <= 24'h000000;
			o_misaligned <= 1'b0;
			o_rd_req     <= 1'b0;
			rd_pend      <= 1'b0;
			rd_byte      <= 8'h00;
		end else begin
			o_rd_req <= to_data || (nib_step && nib);
			rd_pend  <= o_rd_req;
			if (rd_pend)
				rd_byte <= i_rd_data;
			if (addr_done) begin
				o_rd_addr    <= sh_next;
				start_addr   <= sh_next;
				// RQ1 RQ9 alignment flagged, not corrected
				o_misaligned <= |(sh_next & align);
			end else if (nib_step && nib) begin
				o_rd_addr <= addr_nx;
			end
		end
	end

	// ------------------------------------------------------------
	// data output
	// ------------------------------------------------------------
	// RQ12 drive only from the first data fall; release in step with the phase
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			o_io_out  <= 4'h0;
			o_io_oe_b <= 4'hf;
			nib       <= 1'b0;
		end else if (next_phase != qwr_pkg::qwr_ph_data) begin
			o_io_oe_b <= 4'hf;
			nib       <= 1'b0;
		end else if (nib_step) begin
			o_io_oe_b <= 4'h0;
			o_io_out  <= nib ? rd_byte[3:0] : rd_byte[7:4];
			nib       <= ~nib;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_word_gate: assert property (opc_done && opc == `QWR_OP_WORD && !i_quad_lane_enable_bit // RQ2
		|=> phase == qwr_pkg::qwr_ph_ignore) else $error("word read taken without quad enable");
	a_octal_gate: assert property (opc_done && opc == `QWR_OP_OCTAL && !i_quad_lane_enable_bit // RQ10
		|=> phase == qwr_pkg::qwr_ph_ignore) else $error("octal read taken without quad enable");
	a_wrap_gate: assert property (!i_quad_lane_enable_bit && !o_soft_reset // RQ18
		|=> $stable(o_wrap_control_bits)) else $error("wrap bits changed without quad enable");
	a_cont_skip: assert property (frame_go && cont_on && !frame_end // RQ4
		|=> phase == qwr_pkg::qwr_ph_addr) else $error("continuous frame did not skip opcode");
	a_cont_normal: assert property (frame_go && !cont_on && !frame_end // RQ5
		|=> phase == qwr_pkg::qwr_ph_opcode) else $error("normal frame did not expect opcode");
	a_soft_keep: assert property (o_soft_reset // RQ7
		|-> o_continuous_read_bits == $past(o_continuous_read_bits)) else $error("soft reset hit mode");
	a_crm_clear: assert property (opc_done && op_crm && !frame_end // RQ8
		|=> o_continuous_read_bits == `QWR_CONT_RESET) else $error("mode bits not cleared");
	a_wrap_default: assert property ($rose(i_rst_b) // RQ15
		|-> o_wrap_control_bits == `QWR_WRAP_RESET) else $error("wrap not disabled after reset");
	a_word_dummy: assert property (to_data && kind == qwr_pkg::qwr_kind_word // RQ1
		|-> phase == qwr_pkg::qwr_ph_dummy) else $error("word read skipped dummy clocks");
	a_octal_nodummy: assert property (to_data && kind == qwr_pkg::qwr_kind_octal // RQ9
		|-> phase == qwr_pkg::qwr_ph_mode) else $error("octal read used dummy clocks");
	a_wrap_section: assert property (phase == qwr_pkg::qwr_ph_data && wrap_on // RQ16
		|-> (o_rd_addr & ~wrap_mask) == (start_addr & ~wrap_mask)) else $error("read left section");
	a_oe_phase: assert property (o_io_oe_b != 4'hf // RQ12
		|-> phase == qwr_pkg::qwr_ph_data) else $error("lanes driven outside data phase");

	c_cont_frame: cover property (frame_go && cont_on);
	c_wrap_read: cover property (nib_step && wrap_on && addr_nx == (start_addr & ~wrap_mask));
	c_octal_data: cover property (to_data && kind == qwr_pkg::qwr_kind_octal);
	c_set_wrap: cover property (wbits_done);

endmodule

/* qwr_host_model.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------
// host quad controller model
// ------------------------------------------------------------
// serial clock is eight system clocks and stands low between frames
module qwr_host_model (
	// system clock
	input  wire logic          i_clk,
	// host pins and data sample strobe
	output qwr_pkg::qwr_pins_t o_pins,
	output logic               o_sample
);
	logic       sclk;
	logic       cs_b;
	logic       rel;
	logic       tick;
	logic [3:0] drv;

	initial begin
		sclk = 1'h0;
		cs_b = 1'h1;
		rel = 1'h1;
		tick = 1'h0;
		drv = 4'h0;
		o_sample = 1'h0;
	end

	// released lanes move every cycle so a stale nibble never passes for data
	always @(negedge i_clk) begin
		tick <= ~tick;
	end
	assign o_pins = '{sclk: sclk, cs_b: cs_b, io: rel ? (~drv ^ {4{tick}}) : drv};

	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask

	task automatic begin_frame();
		cs_b = 1'h0;
		wait_n(4);
	endtask

	// one host clock, nibble taken by the device on the rise
	task automatic clk_out(input logic [3:0] nib, input logic last);
		rel = 1'h0;
		drv = nib;
		wait_n(4);
		sclk = 1'h1;
		wait_n(3);
		rel = last;
		wait_n(1);
		sclk = 1'h0;
	endtask

	// one data clock; the nibble of the previous fall is sampled before this fall
	task automatic clk_in();
		wait_n(4);
		sclk = 1'h1;
		wait_n(3);
		o_sample = 1'h1;
		wait_n(1);
		o_sample = 1'h0;
		sclk = 1'h0;
	endtask

	task automatic end_frame();
		wait_n(2);
		cs_b = 1'h1;
		rel = 1'h1;
		wait_n(8);
	endtask

	// opcode on lane zero msb first
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			clk_out({3'h0, b[i]}, 1'h0);
		end
	endtask
endmodule

/* test_quad_word_read_wrap_logic.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------
// bench for the quad word read and wrap logic
// ------------------------------------------------------------
module test_quad_word_read_wrap_logic;
	logic               i_clk;
	logic               i_rst_b;
	logic               qe;
	logic               four_wire_command_mode;
	logic [7:0]         rd_data;
	logic [3:0]         io_out;
	logic [3:0]         io_oe_b;
	logic [23:0]        rd_addr;
	logic               rd_req;
	logic [7:0]         cont_bits;
	logic [2:0]         wrap_bits;
	logic               misaligned;
	logic               soft_reset;
	logic               smp;
	qwr_pkg::qwr_pins_t pins;
	logic [3:0]         io_wire;
	logic [3:0]         expq[$];
	logic [3:0]         exp_n;
	logic [31:0]        seed;
	logic [31:0]        r;
	int                 err_total;
	int                 tests_run;
	int                 rd_cnt;
	int                 sr_cnt;
	int                 cyc;
	int                 n0;

	initial i_clk = 1'h0;
	always #10 i_clk = ~i_clk;

	// lane level: device wins where it enables, else the host side
	assign io_wire = (io_out & ~io_oe_b) | (pins.io & io_oe_b);

	qwr_core dut (
		.i_clk                  (i_clk),
		.i_rst_b                (i_rst_b),
		.i_sclk                 (pins.sclk),
		.i_cs_b                 (pins.cs_b),
		.i_io                   (io_wire),
		.o_io_out               (io_out),
		.o_io_oe_b              (io_oe_b),
		.i_quad_lane_enable_bit (qe),
		.i_four_wire_command_mode (four_wire_command_mode),
		.o_rd_addr              (rd_addr),
		.o_rd_req               (rd_req),
		.i_rd_data              (rd_data),
		.o_continuous_read_bits (cont_bits),
		.o_wrap_control_bits    (wrap_bits),
		.o_misaligned           (misaligned),
		.o_soft_reset           (soft_reset)
	);

	qwr_host_model host (
		.i_clk    (i_clk),
		.o_pins   (pins),
		.o_sample (smp)
	);

	// array content is a hash of the address, so a wrong address shows
	function automatic logic [7:0] pat(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
	endfunction

	function automatic logic [23:0] step(input logic [23:0] a, input logic [23:0] m);
		return (m == 24'h0) ? a + 24'h1 : (a & ~m) | ((a + 24'h1) & m);
	endfunction

	task automatic check(input logic [23:0] got, input logic [23:0] exp, input string msg);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask

	task automatic results();
		$display("errors %0d, comparisons %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// array answers half a cycle after each request, on the falling edge; pulses are counted too
	always @(negedge i_clk) begin
		if (rd_req === 1'h1) begin
			rd_data <= pat(rd_addr);
			rd_cnt <= rd_cnt + 1;
		end
		if (soft_reset === 1'h1) begin
			sr_cnt <= sr_cnt + 1;
		end
	end

	// each sampled nibble is matched against the oldest note
	always @(posedge i_clk) begin
		if (smp === 1'h1) begin
			exp_n = (expq.size() > 0) ? expq.pop_front() : 4'hx;
			tests_run++;
			if (io_out !== exp_n || io_oe_b !== 4'h0) begin
				err_total++;
				$display("wrong value at %0t: read nibble", $time);
			end
		end
	end

	// hang guard, well above the few hundred serial clocks used
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			$display("wrong value at %0t: timeout", $time);
			results();
		end
	end

	task automatic send_op(input logic [7:0] op);
		if (four_wire_command_mode) begin
			host.clk_out(op[7:4], 1'h0);
			host.clk_out(op[3:0], 1'h0);
		end else begin
			host.send_byte(op);
		end
	endtask

	task automatic op_frame(input logic [7:0] op);
		host.begin_frame();
		send_op(op);
		host.end_frame();
	endtask

	// quad read; nb bytes noted then clocked out; wm is the wrap mask or zero
	task automatic do_read(input logic [7:0] op, input logic cont, input logic [23:0] a,
		input logic [7:0] m, input int nb, input logic [23:0] wm);
		logic [23:0] p;
		logic [7:0]  d;
		p = a;
		host.begin_frame();
		if (!cont) send_op(op);
		for (int i = 5; i >= 0; i--) host.clk_out(a[i*4 +: 4], 1'h0);
		host.clk_out(m[7:4], 1'h0);
		host.clk_out(m[3:0], (op == 8'he3) && (nb > 0));
		if (op == 8'he7) begin
			host.clk_out(4'h0, 1'h0);
			host.clk_out(4'h0, nb > 0);
		end
		for (int i = 0; i < nb; i++) begin
			d = pat(p);
			expq.push_back(d[7:4]);
			expq.push_back(d[3:0]);
			p = step(p, wm);
		end
		repeat (2 * nb) host.clk_in();
		host.end_frame();
		check(io_oe_b, 4'hf, "lanes released");
	endtask

	task automatic set_wrap(input logic [7:0] w);
		host.begin_frame();
		send_op(8'h77);
		repeat (6) host.clk_out(4'h9, 1'h0);
		host.clk_out(w[7:4], 1'h0);
		host.clk_out(w[3:0], 1'h0);
		host.end_frame();
	endtask

	initial begin
		seed = 32'hc03dda65;
		i_rst_b = 1'h0;
		qe = 1'h1;
		four_wire_command_mode = 1'h0;
		rd_data = 8'h00;
		{err_total, tests_run, rd_cnt, sr_cnt, cyc} = '0;
		repeat (2) @(negedge i_clk);
		i_rst_b = 1'h1;
		repeat (4) @(negedge i_clk);
		check(wrap_bits, 3'h1, "wrap reset");
		check(cont_bits, 8'h00, "mode reset");
		r = $random(seed);
		do_read(8'he7, 1'h0, {r[23:1], 1'h0}, {4'h2, r[27:24]}, 3, 24'h0);
		check(cont_bits, 8'h20, "mode upper nibble");
		do_read(8'he7, 1'h1, {r[22:0], 1'h0}, 8'hf5, 2, 24'h0);
		check(cont_bits, 8'hf0, "mode after cont frame");
		do_read(8'he3, 1'h0, {r[23:4], 4'h0}, 8'h27, 3, 24'h0);
		check(misaligned, 1'h0, "aligned octal");
		do_read(8'he3, 1'h1, {r[19:0], 4'h0}, 8'h2a, 2, 24'h0);
		host.begin_frame();
		repeat (8) host.clk_out(4'h1, 1'h0);
		host.end_frame();
		check(cont_bits[5:4], 2'h1, "exit continuous");
		do_read(8'he7, 1'h0, {r[23:1], 1'h1}, 8'h00, 2, 24'h0);
		check(misaligned, 1'h1, "odd word address");
		do_read(8'he3, 1'h0, {r[23:4], 4'h8}, 8'h00, 1, 24'h0);
		check(misaligned, 1'h1, "unaligned octal");
		qe = 1'h0;
		n0 = rd_cnt;
		do_read(8'he7, 1'h0, 24'h000100, 8'h20, 0, 24'h0);
		do_read(8'he3, 1'h0, 24'h000200, 8'h20, 0, 24'h0);
		set_wrap(8'h60);
		check(rd_cnt, n0, "refused reads");
		check(wrap_bits, 3'h1, "refused wrap");
		check(cont_bits, 8'h00, "refused mode");
		qe = 1'h1;
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			set_wrap({1'h1, k[1:0], 5'h0b});
			check(wrap_bits, {k[1:0], 1'h0}, "wrap bits");
			do_read(8'he7, 1'h0, {r[23:8], 8'h0} + (24'h8 << k) - 24'h2, 8'h00, 4,
				(24'h8 << k) - 24'h1);
		end
		four_wire_command_mode = 1'h1;
		do_read(8'he7, 1'h0, {r[23:8], 8'h3e}, 8'h00, 4, 24'h0);
		check(wrap_bits, 3'h6, "wrap kept in four-wire mode");
		four_wire_command_mode = 1'h0;
		set_wrap(8'h10);
		check(wrap_bits, 3'h1, "wrap off");
		do_read(8'he7, 1'h0, {r[23:8], 8'h06}, 8'h00, 3, 24'h0);
		do_read(8'he7, 1'h0, 24'h000040, 8'hf0, 1, 24'h0);
		n0 = sr_cnt;
		op_frame(8'h66);
		op_frame(8'h99);
		check(sr_cnt, n0 + 1, "soft reset pulse");
		check(cont_bits, 8'hf0, "mode kept over soft reset");
		op_frame(8'hff);
		check(cont_bits, 8'h00, "mode reset command");
		check(expq.size(), 0, "all nibbles seen");
		results();
	end
endmodule
